// >>> hdl/clk_ctrl.sv
// Clock source select, system PLL settings and reference clock generator behind APB
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
module clk_ctrl #(
  parameter int SYNC_CYCLES = clk_ctrl_pkg::SWITCH_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] fuse_clock_config_word,
  input wire logic failsafe_monitor_fail,
  input wire logic wait_executed,
  input wire logic wake_event,
  input wire logic [9:0] ref_src_clk,
  output logic [2:0] sys_clk_source,
  output logic [8:0] fast_osc_postdivider,
  output logic [8:0] pll_output_divider,
  output logic [4:0] pll_multiplier,
  output logic pll_input_select,
  output logic secondary_osc_enable,
  output logic sleep_mode,
  output logic idle_mode,
  output logic refclk_output_pin,
  output logic refclk_output_oe
);
  localparam int SW_BOUND = 12;
  localparam int DIVSW_BOUND = 1000;

  // Divider code to ratio; code 7 jumps to 256, not 128
  function automatic logic [8:0] ratio_of(input logic [2:0] code);
    ratio_of = (code == 3'h7) ? 9'h100 : 9'(9'h001 << code);
  endfunction

  // APB decode
  wire setup_phase = psel & ~penable;
  wire write_done = psel & penable & pwrite & pready;
  wire hit_osc = paddr == clk_ctrl_pkg::OSC_CTRL_ADDR;
  wire hit_pll = paddr == clk_ctrl_pkg::PLL_CTRL_ADDR;
  wire hit_ref = paddr == clk_ctrl_pkg::REF_CTRL_ADDR;
  wire hit_unl = paddr == clk_ctrl_pkg::UNLOCK_ADDR;
  wire mapped = hit_osc | hit_pll | hit_ref | hit_unl;

  logic fuse_load_reg;
  logic unlocked_reg, key1_seen_reg;
  logic [2:0] frc_div_reg, cur_src_reg, next_src_reg;
  logic lock_reg, sleep_en_reg, fail_reg, secondary_oscillator_reg, switch_reg;
  logic [2:0] pll_odiv_reg;
  logic [6:0] pll_mult_reg;
  logic pll_iclk_reg;
  logic [14:0] ref_div_reg, div_work_reg, cnt_reg;
  logic ref_on_reg, ref_stop_in_idle_reg, ref_oe_reg, ref_refclk_run_in_sleep_reg, divsw_reg, active_reg;
  logic [3:0] ref_src_reg;
  logic gen_out_reg, src_prev_reg;
  logic [9:0] sync1_reg, sync2_reg;
  clk_ctrl_pkg::switch_state_t sw_state_reg, sw_state_next;
  logic [$clog2(SYNC_CYCLES + 1)-1:0] sw_cnt_reg;

  // Protected writes consume the unlock
  wire osc_wr = write_done & hit_osc & unlocked_reg;
  wire pll_wr = write_done & hit_pll & unlocked_reg & ~lock_reg;
  wire ref_wr = write_done & hit_ref;
  wire unl_wr = write_done & hit_unl;
  wire sel_change_ok = osc_wr & ~lock_reg;

  wire [31:0] osc_rd = {5'h00, frc_div_reg, 9'h000, cur_src_reg, 1'b0, next_src_reg,
                        lock_reg, 2'h0, sleep_en_reg, fail_reg, 1'b0, secondary_oscillator_reg, switch_reg};
  wire [31:0] pll_rd = {5'h00, pll_odiv_reg, 1'b0, pll_mult_reg, 8'h00, pll_iclk_reg, 7'h00};
  wire [31:0] ref_rd = {1'b0, ref_div_reg, ref_on_reg, 1'b0, ref_stop_in_idle_reg, ref_oe_reg,
                        ref_refclk_run_in_sleep_reg, 1'b0, divsw_reg, active_reg, 4'h0, ref_src_reg};
  wire [31:0] rd_mux = hit_osc ? osc_rd : hit_pll ? pll_rd : hit_ref ? ref_rd :
                       hit_unl ? {31'h00000000, unlocked_reg} : clk_ctrl_pkg::READ_ZERO;

  // Zero wait state: data captured in setup, answered in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= (setup_phase & ~pwrite) ? rd_mux : prdata;
      pready <= setup_phase;
      pslverr <= setup_phase & ~mapped;
    end
  end

  // Two-key unlock, good for one protected write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key1_seen_reg <= 1'b0;
      unlocked_reg <= 1'b0;
    end else if (unl_wr) begin
      key1_seen_reg <= pwdata == clk_ctrl_pkg::UNLOCK_KEY1;
      unlocked_reg <= key1_seen_reg & (pwdata == clk_ctrl_pkg::UNLOCK_KEY2);
    end else if (write_done & (hit_osc | hit_pll)) begin
      unlocked_reg <= 1'b0;
    end
  end

  // Fuse values caught on the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_load_reg <= 1'b1;
    end else begin
      fuse_load_reg <= 1'b0;
    end
  end

  wire [2:0] fuse_src = fuse_clock_config_word[clk_ctrl_pkg::FUSE_SRC_LSB +: 3];
  wire switch_done = sw_state_reg == clk_ctrl_pkg::SW_HANDOVER;

  // Oscillator select control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frc_div_reg <= clk_ctrl_pkg::FRC_DIV_RESET;
      next_src_reg <= clk_ctrl_pkg::SRC_FRC_DIV;
      cur_src_reg <= clk_ctrl_pkg::SRC_FRC_DIV;
      lock_reg <= 1'b0;
      sleep_en_reg <= 1'b0;
      secondary_oscillator_reg <= 1'b0;
      switch_reg <= 1'b0;
    end else if (fuse_load_reg) begin
      next_src_reg <= fuse_src;
      cur_src_reg <= fuse_src;
      secondary_oscillator_reg <= fuse_clock_config_word[clk_ctrl_pkg::FUSE_SECONDARY_OSCILLATOR_BIT];
      switch_reg <= fuse_clock_config_word[clk_ctrl_pkg::FUSE_TWO_SPEED_BIT];
    end else begin
      if (osc_wr) begin
        frc_div_reg <= pwdata[clk_ctrl_pkg::FRC_DIV_LSB +: 3];
        lock_reg <= lock_reg | pwdata[clk_ctrl_pkg::LOCK_BIT];
        sleep_en_reg <= pwdata[clk_ctrl_pkg::SLEEP_EN_BIT];
        secondary_oscillator_reg <= pwdata[clk_ctrl_pkg::SECONDARY_OSCILLATOR_EN_BIT];
      end
      if (sel_change_ok & ~switch_reg) begin
        next_src_reg <= pwdata[clk_ctrl_pkg::NEXT_SRC_LSB +: 3];
      end
      if (switch_done) begin
        cur_src_reg <= next_src_reg;
        switch_reg <= 1'b0;
      end else if (sel_change_ok & pwdata[clk_ctrl_pkg::SWITCH_BIT]) begin
        switch_reg <= 1'b1;
      end
    end
  end

  // Set beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_reg <= 1'b0;
    end else if (failsafe_monitor_fail) begin
      fail_reg <= 1'b1;
    end else if (osc_wr & ~pwdata[clk_ctrl_pkg::FAIL_BIT]) begin
      fail_reg <= 1'b0;
    end
  end

  // Handover waits SYNC_CYCLES pclk cycles in SW_SYNC, then takes one SW_HANDOVER cycle
  always_comb begin
    sw_state_next = sw_state_reg;
    case (sw_state_reg)
      clk_ctrl_pkg::SW_IDLE:
        if (switch_reg & ~fuse_load_reg) sw_state_next = clk_ctrl_pkg::SW_SYNC;
      clk_ctrl_pkg::SW_SYNC:
        if (32'(sw_cnt_reg) == SYNC_CYCLES - 1) sw_state_next = clk_ctrl_pkg::SW_HANDOVER;
      clk_ctrl_pkg::SW_HANDOVER:
        sw_state_next = clk_ctrl_pkg::SW_IDLE;
      default:
        sw_state_next = clk_ctrl_pkg::SW_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state_reg <= clk_ctrl_pkg::SW_IDLE;
      sw_cnt_reg <= '0;
    end else begin
      sw_state_reg <= sw_state_next;
      sw_cnt_reg <= (sw_state_reg == clk_ctrl_pkg::SW_SYNC) ? sw_cnt_reg + 1'b1 : '0;
    end
  end

  // Reserved codes fall back to divided fast RC, keeping the core clocked
  wire [2:0] eff_src = (cur_src_reg == clk_ctrl_pkg::SRC_RESERVED ||
                        cur_src_reg == clk_ctrl_pkg::SRC_FRC_DIV_ALT0 ||
                        cur_src_reg == clk_ctrl_pkg::SRC_FRC_DIV_ALT1) ?
                       clk_ctrl_pkg::SRC_FRC_DIV : cur_src_reg;
  logic [4:0] mult_factor;
  always_comb begin
    case (pll_mult_reg)
      7'h00: mult_factor = 5'h02;
      7'h01: mult_factor = 5'h03;
      7'h02: mult_factor = 5'h04;
      7'h03: mult_factor = 5'h06;
      7'h04: mult_factor = 5'h08;
      7'h05: mult_factor = 5'h0C;
      7'h06: mult_factor = 5'h18;
      default: mult_factor = 5'h00;
    endcase
  end

  // System PLL control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_odiv_reg <= clk_ctrl_pkg::PLL_ODIV_RESET;
      pll_mult_reg <= clk_ctrl_pkg::PLL_MULT_RESET;
      pll_iclk_reg <= 1'b0;
    end else if (fuse_load_reg) begin
      pll_iclk_reg <= fuse_clock_config_word[clk_ctrl_pkg::FUSE_PLL_SRC_BIT];
    end else if (pll_wr) begin
      pll_odiv_reg <= pwdata[clk_ctrl_pkg::PLL_ODIV_LSB +: 3];
      pll_mult_reg <= pwdata[clk_ctrl_pkg::PLL_MULT_LSB +: 7];
      pll_iclk_reg <= pwdata[clk_ctrl_pkg::PLL_ICLK_BIT];
    end
  end

  // Power mode on wait; any wake returns to run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_mode <= 1'b0;
      idle_mode <= 1'b0;
    end else if (wake_event) begin
      sleep_mode <= 1'b0;
      idle_mode <= 1'b0;
    end else if (wait_executed) begin
      sleep_mode <= sleep_en_reg;
      idle_mode <= ~sleep_en_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_source <= clk_ctrl_pkg::SRC_FRC_DIV;
      fast_osc_postdivider <= 9'h001;
      pll_output_divider <= 9'h001;
      pll_multiplier <= 5'h03;
      pll_input_select <= 1'b0;
      secondary_osc_enable <= 1'b0;
    end else begin
      sys_clk_source <= eff_src;
      fast_osc_postdivider <= ratio_of(frc_div_reg);
      pll_output_divider <= ratio_of(pll_odiv_reg);
      pll_multiplier <= mult_factor;
      pll_input_select <= pll_iclk_reg;
      secondary_osc_enable <= secondary_oscillator_reg;
    end
  end

  // Source clocks come from other domains
  genvar g;
  generate
    for (g = 0; g < clk_ctrl_pkg::REF_SRC_COUNT; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= ref_src_clk[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  // Reserved source codes give a still clock
  wire ref_src_ok = (ref_src_reg <= 4'h9) && ref_src_reg != 4'h6 && ref_src_reg != 4'h8;
  wire src_lvl = ref_src_ok & sync2_reg[ref_src_reg];
  wire src_rise = src_lvl & ~src_prev_reg;
  wire sleep_run = ref_refclk_run_in_sleep_reg & (ref_src_reg != clk_ctrl_pkg::REF_SRC_SYS0);
  wire gen_run = ref_on_reg & ~(idle_mode & ref_stop_in_idle_reg) & ~(sleep_mode & ~sleep_run);
  wire div_bypass = div_work_reg == 15'h0000;
  wire div_term = cnt_reg == div_work_reg - 15'h0001;
  // New ratio is taken while stopped, on a source rise when bypassed, else only on a falling output, so no runt pulse
  wire div_load = ~gen_run | (src_rise & (div_bypass | (div_term & gen_out_reg)));

  // Reference control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_div_reg <= clk_ctrl_pkg::REF_DIV_RESET;
      ref_on_reg <= 1'b0;
      ref_stop_in_idle_reg <= 1'b0;
      ref_oe_reg <= 1'b0;
      ref_refclk_run_in_sleep_reg <= 1'b0;
      ref_src_reg <= clk_ctrl_pkg::REF_SRC_RESET;
    end else if (ref_wr) begin
      ref_div_reg <= pwdata[clk_ctrl_pkg::REF_DIV_LSB +: 15];
      ref_on_reg <= pwdata[clk_ctrl_pkg::REF_ON_BIT];
      ref_stop_in_idle_reg <= pwdata[clk_ctrl_pkg::REF_STOP_IN_IDLE_BIT];
      ref_oe_reg <= pwdata[clk_ctrl_pkg::REF_OE_BIT];
      ref_refclk_run_in_sleep_reg <= pwdata[clk_ctrl_pkg::REF_REFCLK_RUN_IN_SLEEP_BIT];
      ref_src_reg <= pwdata[3:0];
    end
  end

  // Divider switch: busy until the new ratio is in use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divsw_reg <= 1'b0;
      div_work_reg <= clk_ctrl_pkg::REF_DIV_RESET;
    end else if (ref_wr & pwdata[clk_ctrl_pkg::REF_DIVSW_BIT]) begin
      divsw_reg <= 1'b1;
    end else if (div_load & (divsw_reg | ~gen_run)) begin
      divsw_reg <= 1'b0;
      div_work_reg <= ref_div_reg;
    end
  end

  // Generator: toggles every div_work source periods, or follows source when bypassed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_reg <= 1'b0;
      cnt_reg <= 15'h0000;
      gen_out_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_lvl;
      if (~gen_run) begin
        cnt_reg <= 15'h0000;
        gen_out_reg <= 1'b0;
      end else if (div_bypass) begin
        gen_out_reg <= src_lvl;
      end else if (src_rise) begin
        cnt_reg <= div_term ? 15'h0000 : cnt_reg + 15'h0001;
        gen_out_reg <= div_term ? ~gen_out_reg : gen_out_reg;
      end
    end
  end

  // Request drops only once the output has come to rest low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg <= 1'b0;
      refclk_output_pin <= 1'b0;
      refclk_output_oe <= 1'b0;
    end else begin
      active_reg <= ref_on_reg | (active_reg & gen_out_reg);
      refclk_output_pin <= gen_out_reg & ref_oe_reg;
      refclk_output_oe <= ref_oe_reg;
    end
  end

  sequence s_unmapped_setup;
    psel & ~penable & ~mapped;
  endsequence
  sequence s_wait_sleep;
    wait_executed & ~wake_event & sleep_en_reg;
  endsequence

  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    s_unmapped_setup |=> pready & pslverr)
    else $error("unmapped address not answered with error");
  a_lock_holds_source: assert property (@(posedge pclk) disable iff (!presetn)
    lock_reg & ~switch_done & ~fuse_load_reg |=> $stable(next_src_reg) && $stable(pll_mult_reg))
    else $error("source or PLL selection changed while locked");
  a_locked_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    write_done & hit_pll & ~unlocked_reg |=> $stable(pll_odiv_reg) && $stable(pll_iclk_reg))
    else $error("PLL control changed without unlock");
  a_sleep_on_wait: assert property (@(posedge pclk) disable iff (!presetn)
    s_wait_sleep |=> sleep_mode && !idle_mode)
    else $error("wait did not enter sleep");
  a_idle_on_wait: assert property (@(posedge pclk) disable iff (!presetn)
    wait_executed & ~wake_event & ~sleep_en_reg |=> idle_mode && !sleep_mode)
    else $error("wait did not enter idle");
  a_fail_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    failsafe_monitor_fail |=> fail_reg)
    else $error("clock fail flag not set");
  a_switch_completes: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(switch_reg) |-> ##[1:SW_BOUND] (!switch_reg && cur_src_reg == next_src_reg))
    else $error("source switch did not complete");
  a_pin_quiet_off: assert property (@(posedge pclk) disable iff (!presetn)
    !ref_oe_reg |=> !refclk_output_pin && !refclk_output_oe)
    else $error("reference pin driven while output disabled");
  a_active_follows_on: assert property (@(posedge pclk) disable iff (!presetn)
    ref_on_reg |=> active_reg)
    else $error("request status not raised");
  a_sleep_stops_ref: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_mode & ~sleep_run |=> !gen_out_reg)
    else $error("reference output ran in sleep");
  a_divsw_clears: assert property (@(posedge pclk) disable iff (!presetn)
    divsw_reg & ~gen_run & ~ref_wr |=> !divsw_reg)
    else $error("divider switch stuck while stopped");
  a_divsw_bound: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(divsw_reg) & div_bypass & ref_src_ok |-> ##[0:DIVSW_BOUND] !divsw_reg)
    else $error("divider switch did not finish");
endmodule // clk_ctrl

// >>> inc/clk_ctrl_pkg.sv
// Constants for the clock source, system PLL and reference clock control block
package clk_ctrl_pkg;
  // Register byte addresses
  localparam logic [7:0] OSC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] PLL_CTRL_ADDR = 8'h10;
  localparam logic [7:0] REF_CTRL_ADDR = 8'h20;
  localparam logic [7:0] UNLOCK_ADDR = 8'h30;
  // Unlock keys, arbitrary values
  localparam logic [31:0] UNLOCK_KEY1 = 32'h5A5AC3C3;
  localparam logic [31:0] UNLOCK_KEY2 = 32'hC3C35A5A;
  // Oscillator select control fields
  localparam int FRC_DIV_LSB = 24;
  localparam int CUR_SRC_LSB = 12;
  localparam int NEXT_SRC_LSB = 8;
  localparam int LOCK_BIT = 7;
  localparam int SLEEP_EN_BIT = 4;
  localparam int FAIL_BIT = 3;
  localparam int SECONDARY_OSCILLATOR_EN_BIT = 1;
  localparam int SWITCH_BIT = 0;
  // System PLL control fields, plus the fast RC divider reset value
  localparam int PLL_ODIV_LSB = 24;
  localparam int PLL_MULT_LSB = 16;
  localparam int PLL_ICLK_BIT = 7;
  localparam logic [2:0] PLL_ODIV_RESET = 3'h0;
  localparam logic [6:0] PLL_MULT_RESET = 7'h01;
  localparam logic [2:0] FRC_DIV_RESET = 3'h0;
  // Reference clock control fields
  localparam int REF_DIV_LSB = 16;
  localparam int REF_ON_BIT = 15;
  localparam int REF_STOP_IN_IDLE_BIT = 13;
  localparam int REF_OE_BIT = 12;
  localparam int REF_REFCLK_RUN_IN_SLEEP_BIT = 11;
  localparam int REF_DIVSW_BIT = 9;
  localparam int REF_ACTIVE_BIT = 8;
  localparam logic [14:0] REF_DIV_RESET = 15'h0000;
  localparam logic [3:0] REF_SRC_RESET = 4'h0;
  localparam int REF_SRC_COUNT = 10;
  // Configuration fuse word fields
  localparam int FUSE_SRC_LSB = 0;
  localparam int FUSE_PLL_SRC_BIT = 4;
  localparam int FUSE_SECONDARY_OSCILLATOR_BIT = 6;
  localparam int FUSE_TWO_SPEED_BIT = 7;
  // Source codes
  localparam logic [2:0] SRC_FRC_DIV = 3'h0;
  localparam logic [2:0] SRC_RESERVED = 3'h3;
  localparam logic [2:0] SRC_FRC_DIV_ALT0 = 3'h6;
  localparam logic [2:0] SRC_FRC_DIV_ALT1 = 3'h7;
  localparam logic [3:0] REF_SRC_SYS0 = 4'h0;
  // Switch handover settle time
  localparam int SWITCH_SETTLE_NS = 40;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SWITCH_CYCLES = (SWITCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
  typedef enum logic [1:0] {SW_IDLE, SW_SYNC, SW_HANDOVER} switch_state_t;
endpackage

// >>> verif/tb_clk_ctrl.sv
// Self-checking bench for the clock control block
`timescale 1ns/10ps
module tb_clk_ctrl;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin_d;
  logic failsafe_monitor_fail, wait_executed, wake_event, pll_input_select;
  logic secondary_osc_enable, sleep_mode, idle_mode, refclk_output_pin, refclk_output_oe;
  logic [7:0] paddr, fuse, seed;
  logic [31:0] pwdata, prdata, wd, pll_last;
  logic [9:0] ref_src_clk;
  logic [2:0] sys_clk_source, src_cnt, s, eff;
  logic [8:0] fast_osc_postdivider, pll_output_divider;
  logic [4:0] pll_multiplier;
  logic [4:0] mult_tab [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h18, 5'h00};
  logic [2:0] src_order [8] = '{3'h6, 3'h1, 3'h7, 3'h2, 3'h3, 3'h4, 3'h0, 3'h5};
  note_t notes[$];
  note_t cur;
  int error_cnt = 0, check_count = 0, edge_cnt, e0, n;
  localparam logic [7:0] OSC = clk_ctrl_pkg::OSC_CTRL_ADDR;
  localparam logic [7:0] PLL = clk_ctrl_pkg::PLL_CTRL_ADDR;
  localparam logic [7:0] REF = clk_ctrl_pkg::REF_CTRL_ADDR;

  clk_ctrl #(.SYNC_CYCLES(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fuse_clock_config_word(fuse),
    .failsafe_monitor_fail(failsafe_monitor_fail), .wait_executed(wait_executed),
    .wake_event(wake_event), .ref_src_clk(ref_src_clk), .sys_clk_source(sys_clk_source),
    .fast_osc_postdivider(fast_osc_postdivider), .pll_output_divider(pll_output_divider),
    .pll_multiplier(pll_multiplier), .pll_input_select(pll_input_select),
    .secondary_osc_enable(secondary_osc_enable), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode), .refclk_output_pin(refclk_output_pin),
    .refclk_output_oe(refclk_output_oe));

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [31:0] ratio(input int k);
    return (k == 7) ? 32'h100 : 32'h1 << k;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic fail_wait();
    error_cnt++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    stop_test();
  endtask
  // One APB transfer; the answer is judged by the monitor against the note
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic e);
    int k;
    notes.push_back('{d, m, e});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) fail_wait();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    xfer(1'b0, a, d, m, 1'b0);
  endtask
  // Protected write, always preceded by its own key pair
  task automatic pwr(input logic [7:0] a, input logic [31:0] d);
    wr(clk_ctrl_pkg::UNLOCK_ADDR, clk_ctrl_pkg::UNLOCK_KEY1);
    wr(clk_ctrl_pkg::UNLOCK_ADDR, clk_ctrl_pkg::UNLOCK_KEY2);
    wr(a, d);
  endtask
  // One-cycle strobe: 0 wait, 1 wake, 2 monitor failure
  task automatic pulse(input int which);
    @(posedge pclk);
    if (which == 0) wait_executed <= 1'b1;
    else if (which == 1) wake_event <= 1'b1;
    else failsafe_monitor_fail <= 1'b1;
    @(posedge pclk);
    wait_executed <= 1'b0;
    wake_event <= 1'b0;
    failsafe_monitor_fail <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #500000;
    fail_wait();
  end
  // Slow source clocks, eight pclk cycles a period
  always @(posedge pclk) begin
    src_cnt <= src_cnt + 3'h1;
    ref_src_clk <= {10{src_cnt[2]}};
    pin_d <= refclk_output_pin;
    if (refclk_output_pin === 1'b1 && pin_d === 1'b0) edge_cnt <= edge_cnt + 1;
  end
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        cur = notes.pop_front();
        check(prdata & cur.m, cur.d & cur.m);
        check(32'(pslverr), 32'(cur.e));
      end
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failsafe_monitor_fail = 1'b0;
    wait_executed = 1'b0;
    wake_event = 1'b0;
    fuse = 8'hD2;
    seed = 8'h4E;
    src_cnt = 3'h0;
    ref_src_clk = 10'h000;
    pin_d = 1'b0;
    edge_cnt = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Fuse values reach the outputs two edges after release; look one edge later
    repeat (3) @(posedge pclk);
    check(32'(pll_output_divider), 32'h1);
    check(32'(pll_multiplier), 32'h3);
    check(32'(pll_input_select), 32'h1);
    check(32'(secondary_osc_enable), 32'h1);
    rd(OSC, 32'h0000_0202, 32'h0700_079E);
    rd(PLL, 32'h0001_0080, 32'h07FF_0080);
    wr(PLL, 32'h0600_0000);
    rd(PLL, 32'h0001_0080, 32'h07FF_0080);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wd = {5'h0, i[2:0], 5'h0, i[2:0], 8'h0, seed[0], 7'h0};
      pwr(PLL, wd);
      rd(PLL, wd, 32'h07FF_0080);
      check(32'(pll_output_divider), ratio(i));
      check(32'(pll_multiplier), 32'(mult_tab[i]));
      check(32'(pll_input_select), 32'(seed[0]));
      pll_last = wd;
    end
    // Every source code, each switch to a new effective source
    for (int j = 0; j < 8; j++) begin
      s = src_order[j];
      eff = (s == 3'h3 || s[2:1] == 2'b11) ? 3'h0 : s;
      wd = {5'h0, j[2:0], 13'h0, s, 8'h03};
      pwr(OSC, wd);
      n = 0;
      while (sys_clk_source !== eff && n < 50) begin
        @(posedge pclk);
        n++;
      end
      if (n >= 50) fail_wait();
      check(32'(fast_osc_postdivider), ratio(j));
      rd(OSC, wd & 32'hFFFF_FFFE, 32'h0700_0793);
    end
    for (int sl = 1; sl >= 0; sl--) begin
      pwr(OSC, {21'h0, 3'h5, 3'h0, sl[0], 4'h2});
      pulse(0);
      check({sleep_mode, idle_mode}, {30'h0, sl[0], ~sl[0]});
      pulse(1);
      check({sleep_mode, idle_mode}, 32'h0);
    end
    rd(OSC, 32'h0, 32'h8);
    pulse(2);
    rd(OSC, 32'h8, 32'h8);
    pwr(OSC, 32'h0000_0582);
    pwr(OSC, 32'h0000_0183);
    pwr(PLL, 32'h0600_0000);
    rd(OSC, 32'h0000_0580, 32'h0000_0781);
    rd(PLL, pll_last, 32'h07FF_0080);
    check(32'(sys_clk_source), 32'h5);
    xfer(1'b0, 8'h40, 32'h0, 32'hFFFF_FFFF, 1'b1);
    xfer(1'b1, 8'h44, 32'h1234, 32'h0, 1'b1);
    wr(REF, 32'h0000_9003);
    rd(REF, 32'h0000_9103, 32'h7FFF_BB0F);
    e0 = edge_cnt;
    repeat (40) @(posedge pclk);
    check(32'(refclk_output_oe), 32'h1);
    check(32'(edge_cnt - e0 >= 4), 32'h1);
    wr(REF, 32'h0000_1003);
    n = 0;
    while (refclk_output_pin !== 1'b0 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) fail_wait();
    rd(REF, 32'h0000_1003, 32'h7FFF_BB0F);
    stop_test();
  end
endmodule // tb_clk_ctrl
